//--- hw/ssla_seq_line_adv.v
// Purpose: Sequence set stepping driven by an input line at frame start triggers
// Assumes: All inputs synchronous to pclk; acq_done_in pulses when readout ends
// Notes: Registers over APB, one wait state on every access
//   Control lines and trigger are taken as synchronous; no synchronisers here
//   Settle window restarts on every further change of the selected line
//   Parameter memory is not reset; software loads it before enabling
// Operation
// - Selected input line alone decides stepping
// - Second line behaves exactly like first
// - Steps only at trigger, always upward
// - Enable loads set zero into active set
// - Line low (high when inverted): keep current active set
// - Line high (low when inverted): load next set, use it
// - Indices run zero to total minus one
// - Advance from last set wraps to zero
// - Line change briefly leaves waiting state
// - Triggers while not waiting are discarded
// - Disable after readout, restore pre-enable values
// - Total set count limited to 64
`timescale 1ns/100ps
`include "ssla_consts.vh"

module ssla_seq_line_adv (
  input wire pclk,
  input wire presetn,
  input wire pce,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [`SSLA_AW-1:0] paddr,
  input wire [`SSLA_DW-1:0] pwdata,
  output reg [`SSLA_DW-1:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire line1_in,
  input wire line2_in,
  input wire frame_trig_in,
  input wire acq_done_in,
  output reg [`SSLA_DW-1:0] active_set,
  output reg [`SSLA_IW-1:0] set_index,
  output reg waiting_trig,
  output reg frame_start,
  output reg seq_running
);

  ////////////////////////////////////////////////////////////////////////////
  // State

  reg [`SSLA_CTRL_W-1:0] ctrl_ff;
  reg [`SSLA_TW-1:0] total_ff;
  reg [`SSLA_IW-1:0] saddr_ff;
  reg [`SSLA_DW-1:0] active_ff;
  reg [`SSLA_DW-1:0] base_ff;
  reg [`SSLA_IW-1:0] idx_ff;
  reg seq_on_ff;
  reg drop_ff;
  reg [1:0] state_ff;
  reg [`SSLA_CW-1:0] cnt_ff;
  reg line_prev_ff;
  reg trig_prev_ff;
  reg pready_ff;
  // One word per set; deep enough for the largest allowed total
  reg [`SSLA_DW-1:0] set_mem [0:(1<<`SSLA_IW)-1];

  reg [1:0] nxt_state;
  reg [`SSLA_CW-1:0] nxt_cnt;
  reg [`SSLA_DW-1:0] nxt_active;
  reg [`SSLA_DW-1:0] nxt_base;
  reg [`SSLA_IW-1:0] nxt_idx;
  reg nxt_seq_on;
  reg nxt_drop;
  reg nxt_frame_start;
  reg [`SSLA_DW-1:0] nxt_prdata;
  reg nxt_pslverr;

  // Settle reload, cut on purpose to the counter width
  localparam [31:0] settle_full = `SSLA_SETTLE_CYC - 1;
  localparam [`SSLA_CW-1:0] settle_load = settle_full[`SSLA_CW-1:0];

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode

  wire acc = psel & penable & ~pready_ff;
  wire done = psel & penable & pready_ff;
  wire wr_done = done & pwrite;
  // Full byte address compare; misaligned offsets are unmapped
  wire hit_ctrl = (paddr == `SSLA_OFF_CTRL);
  wire hit_total = (paddr == `SSLA_OFF_TOTAL);
  wire hit_saddr = (paddr == `SSLA_OFF_SADDR);
  wire hit_sdata = (paddr == `SSLA_OFF_SDATA);
  wire hit_active = (paddr == `SSLA_OFF_ACTIVE);
  wire hit_status = (paddr == `SSLA_OFF_STATUS);
  wire hit_any = hit_ctrl | hit_total | hit_saddr | hit_sdata | hit_active | hit_status;

  ////////////////////////////////////////////////////////////////////////////
  // Line and trigger qualification

  // Edge history follows the raw pins, also while the sequencer is off
  wire sel_line = ctrl_ff[`SSLA_CTRL_SRC] ? line2_in : line1_in;
  wire adv_lvl = sel_line ^ ctrl_ff[`SSLA_CTRL_INV];
  wire line_chg = sel_line ^ line_prev_ff;
  wire trig_rise = frame_trig_in & ~trig_prev_ff;
  wire trig_fall = ~frame_trig_in & trig_prev_ff;
  wire trig_edge = ctrl_ff[`SSLA_CTRL_RISE] ? trig_rise : trig_fall;

  wire [`SSLA_TW-1:0] last_idx = total_ff - `SSLA_ONE_T;
  wire at_last = ({1'b0, idx_ff} >= last_idx);
  // Wrap also covers a total shrunk below the current index
  wire [`SSLA_IW-1:0] next_idx = at_last ? `SSLA_IDX0 : idx_ff + `SSLA_ONE_I;

  wire [`SSLA_TW-1:0] wr_total = pwdata[`SSLA_TW-1:0];
  wire wr_total_big = (pwdata[`SSLA_DW-1:`SSLA_TW] != {(`SSLA_DW-`SSLA_TW){1'b0}})
    | (wr_total > `SSLA_TOTAL_MAX);

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer next state

  always @* begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    nxt_active = active_ff;
    nxt_base = base_ff;
    nxt_idx = idx_ff;
    nxt_seq_on = seq_on_ff;
    nxt_drop = drop_ff;
    nxt_frame_start = 1'b0;
    // Sticky discard flag: software write-one clears, a new discard wins
    if (wr_done & hit_status & pwdata[`SSLA_ST_DROP]) begin
      nxt_drop = 1'b0;
    end
    // Active set writable by software only while the sequencer is off
    if (wr_done & hit_active & ~seq_on_ff) begin
      nxt_active = pwdata;
    end
    case (state_ff)
      `SSLA_S_WAIT: begin
        if (seq_on_ff & line_chg) begin
          nxt_state = `SSLA_S_SETTLE;
          nxt_cnt = settle_load;
          if (trig_edge) begin
            nxt_drop = 1'b1;
          end
        end else if (trig_edge) begin
          nxt_state = `SSLA_S_ACQ;
          nxt_frame_start = 1'b1;
          if (seq_on_ff & adv_lvl) begin
            nxt_idx = next_idx;
            nxt_active = set_mem[next_idx];
          end
          // Low level: set and index stay as they are
        end else if (ctrl_ff[`SSLA_CTRL_EN] & ~seq_on_ff) begin
          nxt_seq_on = 1'b1;
          nxt_base = active_ff;
          nxt_idx = `SSLA_IDX0;
          nxt_active = set_mem[`SSLA_IDX0];
        end else if (~ctrl_ff[`SSLA_CTRL_EN] & seq_on_ff) begin
          // Only reached between frames, so readout has finished
          nxt_seq_on = 1'b0;
          nxt_active = base_ff;
          nxt_idx = `SSLA_IDX0;
        end
      end
      `SSLA_S_SETTLE: begin
        if (trig_edge) begin
          nxt_drop = 1'b1;
        end
        if (line_chg) begin
          nxt_cnt = settle_load;
        end else if (cnt_ff == {`SSLA_CW{1'b0}}) begin
          nxt_state = `SSLA_S_WAIT;
        end else begin
          nxt_cnt = cnt_ff - 1'b1;
        end
      end
      `SSLA_S_ACQ: begin
        // Exposure and readout running: no trigger is accepted
        if (trig_edge) begin
          nxt_drop = 1'b1;
        end
        if (acq_done_in) begin
          nxt_state = `SSLA_S_WAIT;
        end
      end
      default: begin
        nxt_state = `SSLA_S_WAIT;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data

  always @* begin
    nxt_prdata = {`SSLA_DW{1'b0}};
    nxt_pslverr = 1'b0;
    if (hit_ctrl) begin
      nxt_prdata[`SSLA_CTRL_W-1:0] = ctrl_ff;
    end else if (hit_total) begin
      nxt_prdata[`SSLA_TW-1:0] = total_ff;
    end else if (hit_saddr) begin
      nxt_prdata[`SSLA_IW-1:0] = saddr_ff;
    end else if (hit_sdata) begin
      nxt_prdata = set_mem[saddr_ff];
    end else if (hit_active) begin
      nxt_prdata = active_ff;
    end else if (hit_status) begin
      nxt_prdata[`SSLA_ST_RUN] = seq_on_ff;
      nxt_prdata[`SSLA_ST_WAIT] = (state_ff == `SSLA_S_WAIT);
      nxt_prdata[`SSLA_ST_DROP] = drop_ff;
      nxt_prdata[`SSLA_ST_IDX+`SSLA_ST_IDX_W-1:`SSLA_ST_IDX] = idx_ff;
    end else begin
      // Unmapped offsets answer with an error and zero data
      nxt_pslverr = ~hit_any;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Parameter set storage, no reset so it maps onto RAM

  always @(posedge pclk) begin
    if (pce & wr_done & hit_sdata) begin
      set_mem[saddr_ff] <= pwdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Configuration registers

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_ff <= `SSLA_CTRL_RST;
      total_ff <= `SSLA_TOTAL_RST;
      saddr_ff <= `SSLA_IDX0;
    end else if (pce) begin
      // Writes land at the edge that completes the access
      if (wr_done & hit_ctrl) begin
        ctrl_ff <= pwdata[`SSLA_CTRL_W-1:0];
      end
      if (wr_done & hit_saddr) begin
        saddr_ff <= pwdata[`SSLA_IW-1:0];
      end
      if (wr_done & hit_total) begin
        // Out of range totals clamp rather than error
        if (wr_total_big) begin
          total_ff <= `SSLA_TOTAL_MAX;
        end else if (wr_total < `SSLA_TOTAL_MIN) begin
          total_ff <= `SSLA_TOTAL_MIN;
        end else begin
          total_ff <= wr_total;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Edge history of the selected line and the trigger

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      line_prev_ff <= 1'b0;
      trig_prev_ff <= 1'b0;
    end else if (pce) begin
      line_prev_ff <= sel_line;
      trig_prev_ff <= frame_trig_in;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer registers

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      active_ff <= `SSLA_ACTIVE_RST;
      base_ff <= `SSLA_ACTIVE_RST;
      idx_ff <= `SSLA_IDX0;
      seq_on_ff <= 1'b0;
      state_ff <= `SSLA_S_WAIT;
      cnt_ff <= {`SSLA_CW{1'b0}};
    end else if (pce) begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      active_ff <= nxt_active;
      base_ff <= nxt_base;
      idx_ff <= nxt_idx;
      seq_on_ff <= nxt_seq_on;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sticky discard flag, kept apart so its set-wins order stays visible

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      drop_ff <= 1'b0;
    end else if (pce) begin
      drop_ff <= nxt_drop;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bus answer, each output from a flip-flop

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_ff <= 1'b0;
      prdata <= {`SSLA_DW{1'b0}};
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else if (pce) begin
      // One wait state: answer registered in the first access cycle
      pready_ff <= acc;
      pready <= acc;
      pslverr <= acc & nxt_pslverr;
      // Read data only with a read answer, so writes show zero
      if (acc & ~pwrite) begin
        prdata <= nxt_prdata;
      end else begin
        prdata <= {`SSLA_DW{1'b0}};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer outputs, each from a flip-flop

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      active_set <= `SSLA_ACTIVE_RST;
      set_index <= `SSLA_IDX0;
      waiting_trig <= 1'b0;
      frame_start <= 1'b0;
      seq_running <= 1'b0;
    end else if (pce) begin
      active_set <= nxt_active;
      set_index <= nxt_idx;
      waiting_trig <= (nxt_state == `SSLA_S_WAIT);
      frame_start <= nxt_frame_start;
      seq_running <= nxt_seq_on;
    end
  end

endmodule

//--- hw/ssla_consts.vh
// Purpose: Constants for the line-controlled sequence set stepper
// Assumes: 25 MHz pclk, APB with 32-bit data
// Notes: Byte offsets, field positions, reset values, timing counts
`ifndef SSLA_CONSTS_VH
`define SSLA_CONSTS_VH

`define SSLA_AW 8
`define SSLA_DW 32
`define SSLA_IW 6
`define SSLA_TW 7

`define SSLA_OFF_CTRL 8'h00
`define SSLA_OFF_TOTAL 8'h04
`define SSLA_OFF_SADDR 8'h08
`define SSLA_OFF_SDATA 8'h0c
`define SSLA_OFF_ACTIVE 8'h10
`define SSLA_OFF_STATUS 8'h14

`define SSLA_CTRL_EN 0
`define SSLA_CTRL_SRC 1
`define SSLA_CTRL_INV 2
`define SSLA_CTRL_RISE 3
`define SSLA_CTRL_W 4
`define SSLA_CTRL_RST 4'h8

`define SSLA_TOTAL_MAX 7'h40
`define SSLA_TOTAL_MIN 7'h01
`define SSLA_TOTAL_RST 7'h40
`define SSLA_ONE_T 7'h01
`define SSLA_ONE_I 6'h01
`define SSLA_IDX0 6'h00
`define SSLA_ACTIVE_RST 32'h00000000

`define SSLA_ST_RUN 0
`define SSLA_ST_WAIT 1
`define SSLA_ST_DROP 2
`define SSLA_ST_IDX 8
`define SSLA_ST_IDX_W 6

`define SSLA_S_WAIT 2'h0
`define SSLA_S_SETTLE 2'h1
`define SSLA_S_ACQ 2'h2

`define SSLA_SETTLE_NS 1000
`define SSLA_CLK_NS 40
`define SSLA_SETTLE_CYC ((`SSLA_SETTLE_NS + `SSLA_CLK_NS - 1) / `SSLA_CLK_NS)
`define SSLA_CW 6

`endif

//--- testbench/ssla_props.sv
// Purpose: Port assertions for the line-driven set stepper
// Assumes: One pclk domain, async active-low reset
// Notes: Bound from tb; both lines always toggle together there
`timescale 1ns/100ps
`include "ssla_consts.vh"
module ssla_props (
  input wire pclk,
  input wire presetn,
  input wire pce,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [`SSLA_AW-1:0] paddr,
  input wire [`SSLA_DW-1:0] pwdata,
  input wire [`SSLA_DW-1:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire line1_in,
  input wire line2_in,
  input wire frame_trig_in,
  input wire acq_done_in,
  input wire [`SSLA_DW-1:0] active_set,
  input wire [`SSLA_IW-1:0] set_index,
  input wire waiting_trig,
  input wire frame_start,
  input wire seq_running
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  ////////////////////////////////////////
  a_idx_step: assert property ($changed(set_index) && $past(seq_running)
    && seq_running |-> frame_start) else $error("index moved without trigger");
  a_idx_up: assert property (frame_start && $changed(set_index)
    |-> set_index == $past(set_index) + `SSLA_ONE_I || set_index == `SSLA_IDX0)
    else $error("index did not step upward");
  a_act_hold: assert property ($changed(active_set) && $past(seq_running, 2)
    && seq_running |-> frame_start) else $error("active set moved alone");
  a_trig_edge: assert property ($rose(frame_start)
    |-> $past(frame_trig_in, 2) != $past(frame_trig_in)) else $error("start w/o edge");
  a_trig_wait: assert property ($rose(frame_start) |-> $past(waiting_trig))
    else $error("start while not waiting");
  a_acq_wait: assert property (frame_start |-> !waiting_trig)
    else $error("waiting during acquisition");
  a_line_stall: assert property (seq_running && $changed(line1_in)
    && $changed(line2_in) |=> !waiting_trig [*8]) else $error("no settle pause");
  a_idle_idx: assert property (!seq_running |-> set_index == `SSLA_IDX0)
    else $error("index nonzero while off");
  a_ready_one: assert property ($rose(penable) && psel |-> !pready ##1 pready)
    else $error("apb wait state wrong");
  c_step: cover property (frame_start && set_index != `SSLA_IDX0);
  c_wrap: cover property (frame_start && set_index == `SSLA_IDX0);
  c_off: cover property ($fell(seq_running));
endmodule

//--- testbench/ssla_equip.sv
// Purpose: External equipment driving control lines, triggers, readout end
// Assumes: Outputs change right after a rising pclk edge
// Notes: The unselected line carries the inverse, so it must be ignored
`timescale 1ns/100ps
module ssla_equip (
  input wire pclk,
  input wire sel,
  input wire rise,
  input wire waiting_trig,
  input wire frame_start,
  output wire line1_in,
  output wire line2_in,
  output wire frame_trig_in,
  output logic acq_done_in = 1'b0
);
  logic act = 1'b0;
  logic lvl = 1'b0;
  ////////////////////////////////////////
  assign line1_in = lvl ^ sel;
  assign line2_in = ~line1_in;
  assign frame_trig_in = act ^ ~rise;
  // Rude shot triggers during the line change on purpose
  task shot(input logic v, input logic rude, output logic got);
    int n;
    begin
      got = 1'b0;
      n = 0;
      @(posedge pclk);
      lvl <= v;
      repeat (2) @(posedge pclk);
      while (!rude && !waiting_trig && n < 100) begin
        @(posedge pclk);
        n++;
      end
      act <= 1'b1;
      repeat (4) begin
        @(negedge pclk);
        got = got | frame_start;
      end
      @(posedge pclk);
      act <= 1'b0;
      acq_done_in <= 1'b1;
      @(posedge pclk);
      acq_done_in <= 1'b0;
    end
  endtask
endmodule

//--- testbench/tb.sv
// Purpose: Self-checking bench for the line-driven set stepper
// Assumes: pce held high, APB answers after one wait state
// Notes: Partner model supplies lines, triggers and readout end
`timescale 1ns/100ps
`include "ssla_consts.vh"
module tb;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, sel = 1'b0, rise = 1'b1;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, rd, k, e;
  logic er, got;
  logic [9:0] lv = 10'b1011110010;
  wire [31:0] prdata, active_set;
  wire [5:0] set_index;
  wire pready, pslverr, line1_in, line2_in, frame_trig_in, acq_done_in;
  wire waiting_trig, frame_start, seq_running;
  int fail_count = 0;
  int check_count = 0;
  ////////////////////////////////////////
  ssla_seq_line_adv i_dut (.pclk(pclk), .presetn(presetn), .pce(1'b1), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .line1_in(line1_in), .line2_in(line2_in),
    .frame_trig_in(frame_trig_in), .acq_done_in(acq_done_in), .active_set(active_set),
    .set_index(set_index), .waiting_trig(waiting_trig), .frame_start(frame_start),
    .seq_running(seq_running));
  ssla_equip i_eq (.pclk(pclk), .sel(sel), .rise(rise), .waiting_trig(waiting_trig),
    .frame_start(frame_start), .line1_in(line1_in), .line2_in(line2_in),
    .frame_trig_in(frame_trig_in), .acq_done_in(acq_done_in));
  task chk(input logic [31:0] g, input logic [31:0] x);
    begin
      check_count++;
      if (g !== x) begin
        fail_count++;
        $display("wrong value at %0t: got %h want %h", $time, g, x);
      end
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    begin
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
        @(posedge pclk);
        n++;
      end while (pready !== 1'b1 && n < 50);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  task finish_test;
    begin
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0) begin
        $display("ALL CHECKS OK");
      end else begin
        $display("CHECKS NOT OK");
      end
      $finish;
    end
  endtask
  initial forever #20 pclk = ~pclk;
  initial begin
    #2000000;
    fail_count++;
    finish_test;
  end
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, `SSLA_OFF_CTRL, 32'h0);
    chk(rd, {28'h0, `SSLA_CTRL_RST});
    apb(1'b0, `SSLA_OFF_TOTAL, 32'h0);
    chk(rd, {25'h0, `SSLA_TOTAL_RST});
    apb(1'b0, 8'h18, 32'h0);
    chk({31'h0, er}, 32'h1);
    for (k = 0; k < 6; k++) begin
      apb(1'b1, `SSLA_OFF_SADDR, k);
      apb(1'b1, `SSLA_OFF_SDATA, 32'ha0 + k);
    end
    apb(1'b1, `SSLA_OFF_ACTIVE, 32'h55);
    apb(1'b1, `SSLA_OFF_TOTAL, 32'h6);
    apb(1'b1, `SSLA_OFF_CTRL, 32'h9);
    repeat (3) @(posedge pclk);
    chk(active_set, 32'ha0);
    e = 0;
    for (k = 0; k < 10; k++) begin
      i_eq.shot(lv[k], 1'b0, got);
      e = lv[k] ? ((e == 5) ? 0 : e + 1) : e;
      chk({26'h0, set_index}, e);
      chk(active_set, 32'ha0 + e);
      chk({31'h0, got}, 32'h1);
    end
    i_eq.shot(1'b0, 1'b1, got);
    chk({31'h0, got}, 32'h0);
    apb(1'b0, `SSLA_OFF_STATUS, 32'h0);
    chk(rd & 32'h4, 32'h4);
    repeat (40) @(posedge pclk);
    chk({31'h0, waiting_trig}, 32'h1);
    apb(1'b1, `SSLA_OFF_STATUS, 32'h4);
    apb(1'b0, `SSLA_OFF_STATUS, 32'h0);
    chk(rd & 32'h7, 32'h3);
    apb(1'b1, `SSLA_OFF_CTRL, 32'h8);
    repeat (3) @(posedge pclk);
    chk({active_set[30:0], seq_running}, {31'h55, 1'b0});
    // Falling-edge mode set before the partner flips its idle level
    apb(1'b1, `SSLA_OFF_CTRL, 32'h6);
    sel <= 1'b1;
    rise <= 1'b0;
    apb(1'b1, `SSLA_OFF_CTRL, 32'h7);
    for (k = 0; k < 2; k++) begin
      i_eq.shot(k[0], 1'b0, got);
      chk({26'h0, set_index}, 32'h1);
      chk(active_set, 32'ha1);
    end
    apb(1'b1, `SSLA_OFF_CTRL, 32'h6);
    repeat (3) @(posedge pclk);
    chk(active_set, 32'h55);
    apb(1'b1, `SSLA_OFF_TOTAL, 32'h64);
    apb(1'b0, `SSLA_OFF_TOTAL, 32'h0);
    chk(rd, 32'h40);
    finish_test;
  end
endmodule
bind ssla_seq_line_adv ssla_props i_props (.pclk(pclk), .presetn(presetn), .pce(pce),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .line1_in(line1_in),
  .line2_in(line2_in), .frame_trig_in(frame_trig_in), .acq_done_in(acq_done_in),
  .active_set(active_set), .set_index(set_index), .waiting_trig(waiting_trig),
  .frame_start(frame_start), .seq_running(seq_running));
